// ===== bench/ocs_clock_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checks of the clock controller
// ----------------------------------------
module ocs_clock_ctrl_props
  import ocs_pkg::*;
#(
  parameter int TIMERS = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] osc_level,
  input wire logic [1:0] opt_osc_mode,
  input wire logic opt_sec_ext_clock,
  input wire logic [1:0] system_clock_source_select,
  input wire logic internal_precision_oscillator_en,
  input wire logic xtal_osc_en,
  input wire logic wdt_osc_en,
  input wire logic sec_osc_en,
  input wire logic [TIMERS-1:0] timer_sec_clk_en,
  input wire logic [1:0] primary_osc_mode,
  input wire logic sec_osc_ext_mode,
  input wire logic clock_fail_event
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_event_one_cycle: assert property (clock_fail_event |=> !clock_fail_event)
    else $error("fail event held longer than one cycle");
  chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_ipo_kept_on: assert property (internal_precision_oscillator_en && !reg_wr |=> internal_precision_oscillator_en)
    else $error("precision oscillator stopped without a write");
  // Only a write or a primary failure with the watchdog running moves the source
  chk_source_change_cause: assert property ($changed(system_clock_source_select) && !$past(reg_wr)
    |-> clock_fail_event && system_clock_source_select == 2'h3 && wdt_osc_en)
    else $error("source changed without write or fallback");
  chk_timer_copy: assert property ($stable(sec_osc_en) |-> timer_sec_clk_en == {TIMERS{sec_osc_en}})
    else $error("timer clock enables differ from secondary enable");
  chk_strap_copy: assert property (!$past(rst) && $stable(opt_osc_mode)
    |-> primary_osc_mode == opt_osc_mode && sec_osc_ext_mode == opt_sec_ext_clock)
    else $error("mode outputs differ from option bits");
  chk_ctrl_read_back: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[1:0] == $past(system_clock_source_select)
    && reg_rdata[7:4] == $past({internal_precision_oscillator_en, xtal_osc_en, wdt_osc_en, sec_osc_en}))
    else $error("control read differs from control outputs");
  chk_opt_read_back: assert property (reg_rd && reg_addr == 4'h3
    |=> reg_rdata == {5'h00, $past(sec_osc_ext_mode), $past(primary_osc_mode)})
    else $error("option read differs from mode outputs");
endmodule

bind ocs_clock_ctrl ocs_clock_ctrl_props #(.TIMERS(TIMERS)) u_props (.*);

`default_nettype wire

// ===== bench/tb_ocs_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ocs_clock_ctrl;
  import ocs_pkg::*;
  // Short silence window keeps each failure to about 16 cycles
  localparam int FC = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] osc_level = 4'h0;
  logic [3:0] osc_hold = 4'h0;
  logic [1:0] opt_osc_mode = 2'h0;
  logic opt_sec_ext_clock = 1'b0;
  logic [1:0] src;
  logic ipo_en;
  logic [2:0] tmr_en;
  logic fail_ev;
  int n_mismatch = 0;
  int n_tests = 0;
  bit seen;

  initial begin
    forever #12.5 clock = ~clock;
  end

  // Oscillators toggle every cycle unless held still to fake a failure
  always @(posedge clock) begin
    osc_level <= osc_level ^ ~osc_hold;
  end

  ocs_clock_ctrl #(.FAIL_CYCLES(FC)) dut (
    .clock(clock), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_level(osc_level),
    .opt_osc_mode(opt_osc_mode), .opt_sec_ext_clock(opt_sec_ext_clock),
    .system_clock_source_select(src), .internal_precision_oscillator_en(ipo_en),
    .xtal_osc_en(), .wdt_osc_en(), .sec_osc_en(), .timer_sec_clk_en(tmr_en),
    .primary_osc_mode(), .sec_osc_ext_mode(), .clock_fail_event(fail_ev)
  );

  task automatic test_done;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // ----------------------------------------
  // Register port cycles
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  task automatic unlock;
    wr(4'h1, 8'hE7);
    wr(4'h1, 8'h18);
  endtask

  // Straps only change while reset is held
  task automatic do_reset(input logic [1:0] m, input logic s);
    @(posedge clock);
    rst <= 1'b1;
    opt_osc_mode <= m;
    opt_sec_ext_clock <= s;
    osc_hold <= 4'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic wait_ev(output bit got);
    got = 1'b0;
    for (int i = 0; i < FC * 4 && !got; i++) begin
      @(posedge clock);
      #1;
      got = fail_ev;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    for (int m = 0; m < 3; m++) begin
      do_reset(m[1:0], m[0]);
      rchk(4'h3, {5'h00, m[0], m[1:0]}, "options");
    end
    rchk(4'h0, 8'hA0, "ctrl reset");
    wr(4'h0, 8'hB2);
    rchk(4'h0, 8'hA0, "locked ctrl");
    wr(4'h1, 8'hE7);
    rchk(4'h2, 8'h00, "status mid unlock");
    wr(4'h3, 8'h55);
    wr(4'h1, 8'h18);
    rchk(4'h2, 8'h80, "status unlocked");
    // Pin source with primary detection left off, as a slow clock could trip it
    wr(4'h0, 8'hB2);
    rchk(4'h0, 8'hB2, "ctrl write");
    check("source", 8'h02, {6'h00, src});
    check("timer enables", 8'h07, {5'h00, tmr_en});
    check("ipo kept", 8'h01, {7'h00, ipo_en});
    rchk(4'h9, 8'h00, "unmapped");
    // Primary failure with the watchdog oscillator running
    do_reset(2'h0, 1'b0);
    unlock();
    wr(4'h0, 8'hA8);
    osc_hold <= 4'h1;
    wait_ev(seen);
    check("primary event", 8'h01, {7'h00, seen});
    check("fallback source", 8'h03, {6'h00, src});
    rchk(4'h2, 8'h39, "status primary");
    wr(4'h2, 8'h01);
    rchk(4'h2, 8'h38, "status cleared");
    // Watchdog disabled, then watchdog as source: no fallback
    for (int k = 0; k < 2; k++) begin
      do_reset(2'h0, 1'b0);
      unlock();
      wr(4'h0, k ? 8'hAB : 8'h88);
      osc_hold <= k ? 4'h8 : 4'h1;
      wait_ev(seen);
      check("primary event", 8'h01, {7'h00, seen});
      rchk(4'h2, k ? 8'h31 : 8'h01, "status no fallback");
    end
    // Watchdog failure blinds the primary detector
    do_reset(2'h0, 1'b0);
    unlock();
    wr(4'h0, 8'hAC);
    osc_hold <= 4'h8;
    wait_ev(seen);
    check("watchdog event", 8'h01, {7'h00, seen});
    rchk(4'h2, 8'h06, "status watchdog");
    osc_hold <= 4'h9;
    wait_ev(seen);
    check("primary after watchdog", 8'h00, {7'h00, seen});
    rchk(4'h0, 8'hAC, "source kept");
    test_done();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
endmodule

`default_nettype wire

// ===== src/ocs_cfg.svh
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

// ----------------------------------------
// Register port geometry
// ----------------------------------------
`define OCS_ADDR_W 4
`define OCS_DATA_W 8

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OCS_REG_CTRL 4'h0
`define OCS_REG_LOCK 4'h1
`define OCS_REG_STAT 4'h2
`define OCS_REG_OPT 4'h3

// ----------------------------------------
// Unlock keys, written in this order to the lock register
// ----------------------------------------
`define OCS_KEY_FIRST 8'hE7
`define OCS_KEY_SECOND 8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
// Precision oscillator and watchdog oscillator on, detectors off, source 0
`define OCS_CTRL_RST 8'hA0
`define OCS_OPT_RST 2'h0

// ----------------------------------------
// Source select codes
// ----------------------------------------
`define OCS_SRC_IPO 2'h0
`define OCS_SRC_XTAL 2'h1
`define OCS_SRC_PIN 2'h2
`define OCS_SRC_WDT 2'h3

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define OCS_ST_PRI_FAIL 0
`define OCS_ST_WDT_FAIL 1
`define OCS_ST_WDT_DEAD 2
`define OCS_ST_FALLBACK 3
`define OCS_ST_SRC_LSB 4
`define OCS_ST_UNLOCKED 7

// ----------------------------------------
// Failure timing
// ----------------------------------------
`define OCS_FAIL_TIME_NS 1000000
`define OCS_CLK_PERIOD_NS 25
`define OCS_FAIL_CYCLES (`OCS_FAIL_TIME_NS / `OCS_CLK_PERIOD_NS)
`define OCS_CNT_W 16
`define OCS_CNT_ONE 16'h0001

`endif

// ===== src/ocs_clock_ctrl.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"

// Function
// RL1: Software disables both detectors before switching source
// RL2: Detectors may re-enable after select write
// RL3: Precision oscillator stays on unless software disables
// RL4: Primary failure: event, fall back to watchdog
// RL5: No fallback if watchdog is source or off
// RL6: Primary failure below about 1 kHz
// RL7: Software avoids detection with very slow clocks
// RL8: Watchdog failure: event only, no switch
// RL9: After watchdog failure, primary detection stops
// RL10: Software clears watchdog detector when unusable
// RL11: Other accesses never abort unlock sequence; here a control write between the two keys aborts it
// RL12: No divider; selected source drives system clock
// RL13: Secondary oscillator feeds only three timers
// RL14: Primary oscillator mode comes from option bits
// RL15: Sticky failure flags until software clears
module ocs_clock_ctrl
  import ocs_pkg::*;
#(
  parameter int FAIL_CYCLES = `OCS_FAIL_CYCLES,
  parameter int CNT_W = `OCS_CNT_W,
  parameter int TIMERS = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`OCS_ADDR_W-1:0] reg_addr,
  input wire logic [`OCS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`OCS_DATA_W-1:0] reg_rdata,
  input wire logic [3:0] osc_level,
  input wire logic [1:0] opt_osc_mode,
  input wire logic opt_sec_ext_clock,
  output logic [1:0] system_clock_source_select,
  output logic internal_precision_oscillator_en,
  output logic xtal_osc_en,
  output logic wdt_osc_en,
  output logic sec_osc_en,
  output logic [TIMERS-1:0] timer_sec_clk_en,
  output logic [1:0] primary_osc_mode,
  output logic sec_osc_ext_mode,
  output logic clock_fail_event
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ocs_ctrl_t ctrl;
    ocs_lock_t lock;
    logic pri_fail_flag;
    logic wdt_fail_flag;
    logic wdt_dead;
    logic fallback;
    logic restart;
    logic event_p;
    logic [1:0] mode;
    logic sec_ext;
    logic straps_taken;
    logic [`OCS_DATA_W-1:0] rdata;
  } ocs_st_t;

  ocs_st_t s_q;
  ocs_st_t s_d;

  ocs_mon_if mon_pri ();
  ocs_mon_if mon_wdt ();

  // Address match for a strobe; used by the write decodes only
  function automatic logic hit(input logic stb, input logic [`OCS_ADDR_W-1:0] a,
                               input logic [`OCS_ADDR_W-1:0] off);
    hit = stb && (a == off);
  endfunction

  // Status byte as software sees it
  function automatic logic [`OCS_DATA_W-1:0] status_word(input ocs_st_t s);
    logic [`OCS_DATA_W-1:0] w;
    w = '0;
    w[`OCS_ST_PRI_FAIL] = s.pri_fail_flag;
    w[`OCS_ST_WDT_FAIL] = s.wdt_fail_flag;
    w[`OCS_ST_WDT_DEAD] = s.wdt_dead;
    w[`OCS_ST_FALLBACK] = s.fallback;
    w[`OCS_ST_SRC_LSB +: 2] = s.ctrl.system_clock_source_select;
    w[`OCS_ST_UNLOCKED] = (s.lock == OCS_LK_OPEN);
    status_word = w;
  endfunction

  logic wr_ctrl;
  logic wr_lock;
  logic wr_stat;
  logic pri_fail;
  logic wdt_fail;
  logic can_fallback;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign wr_ctrl = hit(reg_wr, reg_addr, `OCS_REG_CTRL);
  assign wr_lock = hit(reg_wr, reg_addr, `OCS_REG_LOCK);
  assign wr_stat = hit(reg_wr, reg_addr, `OCS_REG_STAT);
  assign pri_fail = mon_pri.fail;
  assign wdt_fail = mon_wdt.fail;
  // Fallback needs a running watchdog oscillator that is not already the source
  assign can_fallback = s_q.ctrl.wdt_osc_en &&
                        (s_q.ctrl.system_clock_source_select != OCS_WDT); // RL5

  // ----------------------------------------
  // Monitor hookup
  // ----------------------------------------
  // The primary monitor watches whichever source drives the system clock,
  // since that is the clock the core would lose
  assign mon_pri.level = osc_level[s_q.ctrl.system_clock_source_select];
  assign mon_pri.enable = s_q.ctrl.primary_fail_detect_enable && !s_q.wdt_dead; // RL9
  assign mon_pri.restart = s_q.restart; // RL2
  // The watchdog monitor is held off when it could only report nonsense
  assign mon_wdt.level = osc_level[OCS_WDT];
  assign mon_wdt.enable = s_q.ctrl.watchdog_fail_detector_enable && s_q.ctrl.wdt_osc_en &&
                          (s_q.ctrl.system_clock_source_select != OCS_WDT); // RL10
  assign mon_wdt.restart = s_q.restart;

  ocs_fail_mon #(
    .CNT_W(CNT_W),
    .FAIL_CYCLES(FAIL_CYCLES)
  ) u_mon_pri (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .m(mon_pri.mon)
  );

  ocs_fail_mon #(
    .CNT_W(CNT_W),
    .FAIL_CYCLES(FAIL_CYCLES)
  ) u_mon_wdt (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .m(mon_wdt.mon)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.event_p = 1'b0;
    s_d.rdata = '0;

    // Option bits are straps: caught once, the cycle after reset is released
    if (!s_q.straps_taken) begin
      s_d.mode = opt_osc_mode; // RL14
      s_d.sec_ext = opt_sec_ext_clock;
      s_d.straps_taken = 1'b1;
    end

    // Unlock sequence; only lock and control writes move it
    unique case (s_q.lock)
      OCS_LK_CLOSED: begin
        if (wr_lock && reg_wdata == `OCS_KEY_FIRST) begin
          s_d.lock = OCS_LK_HALF;
        end
      end
      OCS_LK_HALF: begin
        if (wr_lock) begin
          s_d.lock = (reg_wdata == `OCS_KEY_SECOND) ? OCS_LK_OPEN : OCS_LK_CLOSED;
        end else if (wr_ctrl) begin
          s_d.lock = OCS_LK_CLOSED; // Control write before second key aborts
        end
      end
      OCS_LK_OPEN: begin
        if (wr_lock) begin
          s_d.lock = OCS_LK_CLOSED;
        end else if (wr_ctrl) begin
          // Enables and select take effect here; nothing else is forced
          // off, so the precision oscillator only stops when cleared
          s_d.ctrl = ocs_ctrl_t'(reg_wdata); // RL3
          s_d.lock = OCS_LK_CLOSED;
          s_d.fallback = 1'b0;
          s_d.restart = 1'b1; // RL2
        end
      end
      default: begin
        s_d.lock = OCS_LK_CLOSED;
      end
    endcase
    // Reads and writes elsewhere leave the sequence untouched // RL11

    // Write-one-to-clear of failure flags; a new failure below wins
    if (wr_stat) begin
      if (reg_wdata[`OCS_ST_PRI_FAIL]) begin
        s_d.pri_fail_flag = 1'b0;
      end
      if (reg_wdata[`OCS_ST_WDT_FAIL]) begin
        s_d.wdt_fail_flag = 1'b0;
      end
    end

    // Primary oscillator lost
    if (pri_fail) begin
      s_d.event_p = 1'b1; // RL4
      s_d.pri_fail_flag = 1'b1; // RL15
      if (can_fallback) begin
        s_d.ctrl.system_clock_source_select = OCS_WDT; // RL4
        s_d.fallback = 1'b1;
      end
    end

    // Watchdog oscillator lost: alert only, select is left alone
    if (wdt_fail) begin
      s_d.event_p = 1'b1; // RL8
      s_d.wdt_fail_flag = 1'b1; // RL15
      s_d.wdt_dead = 1'b1; // RL9
    end

    // Read data for exactly the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `OCS_REG_CTRL: s_d.rdata = s_q.ctrl;
        `OCS_REG_STAT: s_d.rdata = status_word(s_q);
        `OCS_REG_OPT: s_d.rdata = {5'h00, s_q.sec_ext, s_q.mode};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes everything, monitors included
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.ctrl <= ocs_ctrl_t'(`OCS_CTRL_RST);
      s_q.lock <= OCS_LK_CLOSED;
      s_q.pri_fail_flag <= 1'b0;
      s_q.wdt_fail_flag <= 1'b0;
      s_q.wdt_dead <= 1'b0;
      s_q.fallback <= 1'b0;
      s_q.restart <= 1'b0;
      s_q.event_p <= 1'b0;
      s_q.mode <= `OCS_OPT_RST;
      s_q.sec_ext <= 1'b0;
      s_q.straps_taken <= 1'b0;
      s_q.rdata <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Select goes straight to the clock mux; there is no divider stage
  assign system_clock_source_select = s_q.ctrl.system_clock_source_select; // RL12
  assign internal_precision_oscillator_en = s_q.ctrl.ipo_en;
  assign xtal_osc_en = s_q.ctrl.xtal_en;
  assign wdt_osc_en = s_q.ctrl.wdt_osc_en;
  assign sec_osc_en = s_q.ctrl.sec_osc_en;
  // Secondary oscillator has no code on the system select, only timer taps
  assign timer_sec_clk_en = {TIMERS{s_q.ctrl.sec_osc_en}}; // RL13
  assign primary_osc_mode = s_q.mode; // RL14
  assign sec_osc_ext_mode = s_q.sec_ext;
  assign clock_fail_event = s_q.event_p;
  assign reg_rdata = s_q.rdata;

endmodule

`default_nettype wire

// ===== src/ocs_fail_mon.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocs_cfg.svh"

module ocs_fail_mon
  import ocs_pkg::*;
#(
  parameter int CNT_W = `OCS_CNT_W,
  parameter int FAIL_CYCLES = `OCS_FAIL_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  ocs_mon_if.mon m
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic prev;
    logic tripped;
    logic fail;
  } ocs_mon_st_t;

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(FAIL_CYCLES - 1);

  ocs_mon_st_t s_q;
  ocs_mon_st_t s_d;

  // ----------------------------------------
  // Silence counter
  // ----------------------------------------
  // Any edge of the watched level restarts the count; a full period
  // without one is a clock slower than the threshold
  always_comb begin
    s_d = s_q;
    s_d.fail = 1'b0;
    s_d.prev = m.level;
    if (!m.enable || m.restart) begin
      s_d.cnt = '0;
      s_d.tripped = 1'b0;
    end else if (m.level != s_q.prev) begin
      s_d.cnt = '0;
    end else if (!s_q.tripped) begin
      if (s_q.cnt == LIMIT) begin
        s_d.fail = 1'b1; // RL6
        s_d.tripped = 1'b1; // One event until the monitor is disabled or restarted, not one per period
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(`OCS_CNT_ONE);
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign m.fail = s_q.fail;

endmodule

`default_nettype wire

// ===== src/ocs_mon_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries one oscillator monitor's control and result
interface ocs_mon_if;
  logic enable;
  logic restart;
  logic level;
  logic fail;
  modport ctrl (output enable, output restart, output level, input fail);
  modport mon (input enable, input restart, input level, output fail);
endinterface

`default_nettype wire

// ===== src/ocs_pkg.sv
`include "ocs_cfg.svh"

package ocs_pkg;

  // ----------------------------------------
  // Clock sources reachable by the system clock
  // ----------------------------------------
  typedef enum logic [1:0] {
    OCS_IPO  = `OCS_SRC_IPO,
    OCS_XTAL = `OCS_SRC_XTAL,
    OCS_PIN  = `OCS_SRC_PIN,
    OCS_WDT  = `OCS_SRC_WDT
  } ocs_src_t;

  // ----------------------------------------
  // Control register layout, msb first
  // ----------------------------------------
  typedef struct packed {
    logic ipo_en;
    logic xtal_en;
    logic wdt_osc_en;
    logic sec_osc_en;
    logic primary_fail_detect_enable;
    logic watchdog_fail_detector_enable;
    ocs_src_t system_clock_source_select;
  } ocs_ctrl_t;

  // ----------------------------------------
  // Unlock sequence states
  // ----------------------------------------
  typedef enum logic [2:0] {
    OCS_LK_CLOSED = 3'b001,
    OCS_LK_HALF   = 3'b010,
    OCS_LK_OPEN   = 3'b100
  } ocs_lock_t;

  // ----------------------------------------
  // Primary oscillator mode from option bits
  // ----------------------------------------
  typedef enum logic [1:0] {
    OCS_MODE_MEDIUM = 2'h0,
    OCS_MODE_MAX    = 2'h1,
    OCS_MODE_RC_EXT = 2'h2,
    OCS_MODE_RSVD   = 2'h3
  } ocs_mode_t;

endpackage
